/* File: common/pesr_pkg.sv */
// Purpose: Shared constants for the pump enable and sense routing block
// Assumes: AXI4-Lite register access, 32-bit data, word-aligned registers
// Notes:   Offsets and field layouts are local choices, listed in the hand-over
package pesr_pkg;

	// ==========================================================
	// Chip operating modes (inputs to the block)
	typedef enum logic [2:0] {
		PESR_MODE_INIT,
		PESR_MODE_NORMAL,
		PESR_MODE_STOP,
		PESR_MODE_SLEEP,
		PESR_MODE_RESTART,
		PESR_MODE_FAILSAFE
	} pesr_mode_t;

	// ==========================================================
	// Register byte offsets
	localparam logic [7:0] PESR_OFS_PUMP   = 8'h00;
	localparam logic [7:0] PESR_OFS_MEAS   = 8'h04;
	localparam logic [7:0] PESR_OFS_IOCFG  = 8'h08;
	localparam logic [7:0] PESR_OFS_WAKE   = 8'h0C;
	localparam logic [7:0] PESR_OFS_STATUS = 8'h10;
	localparam logic [7:0] PESR_OFS_FLAGS  = 8'h14;

	// ==========================================================
	// Field positions
	localparam int PESR_B_PUMP_EN   = 0;
	localparam int PESR_B_LOCK      = 1;
	localparam int PESR_B_SS_LO     = 4;
	localparam int PESR_B_MEAS_EN   = 0;
	localparam int PESR_B_FO_TEST   = 4;
	localparam int PESR_B_SENSE_WAKE_ENABLE     = 0;
	localparam int PESR_B_IOWK_EN   = 1;
	localparam int PESR_B_OTHER_WK  = 2;
	localparam int PESR_B_PULL_LO   = 4;
	localparam int PESR_B_WCTRL_LO  = 8;
	localparam int PESR_B_ACC_FAULT = 0;
	localparam int PESR_B_WK_FLAG   = 1;
	localparam int PESR_B_IO_FLAG   = 2;
	localparam int PESR_B_WK_LVL    = 3;
	localparam int PESR_B_IO_LVL    = 4;

	// ==========================================================
	// Widths and encodings
	localparam int         PESR_SS_W     = 2;
	localparam int         PESR_IOCFG_W  = 3;
	localparam int         PESR_PULL_W   = 2;
	localparam int         PESR_WCTRL_W  = 4;
	localparam logic [2:0] PESR_IO_OFF   = 3'h0;
	localparam logic [2:0] PESR_IO_FAIL  = 3'h1;
	localparam logic [2:0] PESR_IO_WAKE  = 3'h2;
	localparam logic [1:0] PESR_RESP_OK  = 2'h0;
	localparam logic [1:0] PESR_RESP_ERR = 2'h2;

endpackage

/* File: dv/pesr_core_bench.sv */
// Purpose: Self-checking bench for pump enable and sense routing control
// Assumes: Register map and latencies as handed over by the designer
// Notes:   Output checks wait a few cycles since outputs are registered twice
`timescale 1ns/1ps
`default_nettype none

module pesr_core_bench;
	import pesr_pkg::*;

	logic        aclk = 1'b0, aresetn = 1'b0, go = 1'b0, we = 1'b0, done;
	logic [7:0]  addr = 8'h00, awaddr, araddr;
	logic [31:0] wd = 32'h0, rsp_data, wdata, rdata, v;
	logic [1:0]  rsp_code, bresp, rresp;
	logic [3:0]  wstrb;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	pesr_mode_t  chip_mode = PESR_MODE_INIT;
	logic        sleep_request = 1'b0, supply_overvoltage = 1'b0, hv_sense_input = 1'b0;
	logic        io_pin_level = 1'b0, hv_sense_wake_event = 1'b0, io_pin_wake_event = 1'b0;
	logic        fail_output_request = 1'b0;
	logic        pump_gate_output, measure_switch, pull_enable, fail_output;
	logic        sense_wake_active, io_pin_wake_active, restart_request;
	logic [1:0]  spread_mod_rate, pull_config_out;
	logic [3:0]  wake_control_out;
	logic [2:0]  io_function_out;
	int          failures = 0, n_compared = 0;

	always #20 aclk = ~aclk;

	// ==========================================================
	// Block and its configuring microcontroller
	pesr_core u_dut (.aclk(aclk), .aresetn(aresetn), .clk_en(1'b1),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.chip_mode(chip_mode), .sleep_request(sleep_request), .supply_overvoltage(supply_overvoltage),
		.hv_sense_input(hv_sense_input), .io_pin_level(io_pin_level),
		.hv_sense_wake_event(hv_sense_wake_event), .io_pin_wake_event(io_pin_wake_event),
		.fail_output_request(fail_output_request), .pump_gate_output(pump_gate_output),
		.spread_mod_rate(spread_mod_rate), .measure_switch(measure_switch), .pull_enable(pull_enable),
		.pull_config_out(pull_config_out), .wake_control_out(wake_control_out),
		.io_function_out(io_function_out), .fail_output(fail_output),
		.sense_wake_active(sense_wake_active), .io_pin_wake_active(io_pin_wake_active),
		.restart_request(restart_request));
	pesr_mcu_model u_mcu (.aclk(aclk), .aresetn(aresetn), .go(go), .we(we), .addr(addr), .data(wd),
		.done(done), .rsp_data(rsp_data), .rsp_code(rsp_code), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

	// ==========================================================
	// Shared tasks
	task automatic summarize();
		$display("compared %0d mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			failures++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// One transfer; bounded wait for the answer
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		go <= 1'b1;
		we <= w;
		addr <= a;
		wd <= d;
		@(posedge aclk);
		go <= 1'b0;
		for (i = 0; i < 40; i++) begin
			@(posedge aclk);
			if (done === 1'b1) break;
		end
		if (i == 40) begin
			failures++;
			summarize();
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a);
		bus(1'b0, a, 32'h0);
		v = rsp_data;
	endtask

	task automatic settle();
		repeat (4) @(posedge aclk);
	endtask

	task automatic set_mode(input pesr_mode_t m);
		chip_mode <= m;
		settle();
	endtask

	// ==========================================================
	// Scenarios
	task automatic sc_pump();
		wr(PESR_OFS_PUMP, 32'h1);
		settle();
		check(pump_gate_output, 1'b0);
		rd(PESR_OFS_PUMP);
		check(v[PESR_B_PUMP_EN], 1'b0);
		set_mode(PESR_MODE_NORMAL);
		for (int s = 1; s < 4; s++) begin
			wr(PESR_OFS_PUMP, 32'h1 | (s << PESR_B_SS_LO));
			settle();
			check(spread_mod_rate, s[1:0]);
		end
		check(pump_gate_output, 1'b1);
		wr(PESR_OFS_PUMP, 32'h3);
		wr(PESR_OFS_PUMP, 32'h2);
		settle();
		check(pump_gate_output, 1'b1);
		rd(PESR_OFS_PUMP);
		check(v[PESR_B_PUMP_EN], 1'b1);
		// Overvoltage raised in every retention mode
		supply_overvoltage <= 1'b1;
		for (int m = 2; m < 6; m++) begin
			set_mode(pesr_mode_t'(m));
			check(pump_gate_output, 1'b1);
		end
		set_mode(PESR_MODE_NORMAL);
		check(pump_gate_output, 1'b1);
		supply_overvoltage <= 1'b0;
		wr(PESR_OFS_PUMP, 32'h1);
		wr(PESR_OFS_PUMP, 32'h0);
		settle();
		check(pump_gate_output, 1'b0);
	endtask

	task automatic sc_meas();
		wr(PESR_OFS_IOCFG, PESR_IO_FAIL);
		wr(PESR_OFS_MEAS, 32'h1);
		settle();
		check(measure_switch, 1'b0);
		rd(PESR_OFS_FLAGS);
		rd(PESR_OFS_FLAGS);
		check(v[PESR_B_ACC_FAULT], 1'b1);
		wr(PESR_OFS_FLAGS, 32'h1);
		rd(PESR_OFS_FLAGS);
		check(v[PESR_B_ACC_FAULT], 1'b0);
		wr(PESR_OFS_IOCFG, PESR_IO_OFF);
		wr(PESR_OFS_WAKE, 32'hA33);
		wr(PESR_OFS_MEAS, 32'h11);
		fail_output_request <= 1'b1;
		settle();
		check(measure_switch, 1'b1);
		check(pull_enable, 1'b0);
		check({wake_control_out, pull_config_out}, 6'h00);
		check(fail_output, 1'b0);
		check({sense_wake_active, io_pin_wake_active}, 2'h0);
		rd(PESR_OFS_WAKE);
		check(v, 32'hA33);
		hv_sense_wake_event <= 1'b1;
		io_pin_wake_event <= 1'b1;
		hv_sense_input <= 1'b1;
		@(posedge aclk);
		hv_sense_wake_event <= 1'b0;
		io_pin_wake_event <= 1'b0;
		settle();
		rd(PESR_OFS_FLAGS);
		check(v[2:1], 2'h0);
		rd(PESR_OFS_STATUS);
		check(v[PESR_B_WK_LVL], 1'b0);
		// Io config writes land but stay without effect while measuring
		wr(PESR_OFS_IOCFG, PESR_IO_FAIL);
		settle();
		check(fail_output, 1'b0);
		check(io_function_out, PESR_IO_OFF);
		wr(PESR_OFS_IOCFG, PESR_IO_WAKE);
		settle();
		check(io_pin_wake_active, 1'b0);
		rd(PESR_OFS_FLAGS);
		check(v[PESR_B_ACC_FAULT], 1'b1);
		wr(PESR_OFS_FLAGS, 32'h1);
		set_mode(PESR_MODE_STOP);
		check(measure_switch, 1'b0);
		rd(PESR_OFS_MEAS);
		check(v[PESR_B_MEAS_EN], 1'b1);
		set_mode(PESR_MODE_FAILSAFE);
		check({measure_switch, sense_wake_active}, 2'h0);
		set_mode(PESR_MODE_NORMAL);
		check(measure_switch, 1'b1);
	endtask

	task automatic sc_sleep();
		logic seen;
		// Second pass adds another wake source, so sleep must be allowed
		for (int k = 0; k < 2; k++) begin
			seen = 1'b0;
			sleep_request <= 1'b1;
			for (int i = 0; i < 8; i++) begin
				@(posedge aclk);
				if (i == 0) sleep_request <= 1'b0;
				if (restart_request === 1'b1) seen = 1'b1;
			end
			check(seen, k == 0);
			rd(PESR_OFS_FLAGS);
			check(v[PESR_B_ACC_FAULT], k == 0);
			wr(PESR_OFS_FLAGS, 32'h1);
			wr(PESR_OFS_WAKE, 32'hA37);
		end
	endtask

	task automatic sc_release();
		wr(PESR_OFS_MEAS, 32'h0);
		settle();
		// Stored wake and io settings take effect again
		check({wake_control_out, pull_config_out}, 6'h2B);
		check({io_function_out, sense_wake_active, io_pin_wake_active}, {PESR_IO_WAKE, 2'h3});
		rd(PESR_OFS_STATUS);
		check(v[PESR_B_WK_LVL], 1'b1);
		wr(PESR_OFS_WAKE, 32'h0);
		settle();
		check({measure_switch, pull_enable}, 2'h1);
		set_mode(PESR_MODE_FAILSAFE);
		check(sense_wake_active, 1'b1);
		set_mode(PESR_MODE_NORMAL);
		rd(8'h18);
		check(rsp_code, PESR_RESP_ERR);
		check(v, 32'h0);
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		check({measure_switch, pump_gate_output}, 2'h0);
		rd(PESR_OFS_MEAS);
		check(v[PESR_B_MEAS_EN], 1'b0);
		sc_pump();
		sc_meas();
		sc_sleep();
		sc_release();
		summarize();
	end
endmodule
`default_nettype wire

/* File: dv/pesr_mcu_model.sv */
// Purpose: Microcontroller-side AXI4-Lite master that configures the block
// Assumes: One transfer at a time, started by a one-cycle go strobe while idle
// Notes:   done stays high from the response until the next go
`timescale 1ns/1ps
`default_nettype none

module pesr_mcu_model (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        go,
	input  wire logic        we,
	input  wire logic [7:0]  addr,
	input  wire logic [31:0] data,
	output var  logic        done,
	output var  logic [31:0] rsp_data,
	output var  logic [1:0]  rsp_code,
	output var  logic [7:0]  awaddr,
	output var  logic        awvalid,
	input  wire logic        awready,
	output var  logic [31:0] wdata,
	output var  logic [3:0]  wstrb,
	output var  logic        wvalid,
	input  wire logic        wready,
	input  wire logic [1:0]  bresp,
	input  wire logic        bvalid,
	output var  logic        bready,
	output var  logic [7:0]  araddr,
	output var  logic        arvalid,
	input  wire logic        arready,
	input  wire logic [31:0] rdata,
	input  wire logic [1:0]  rresp,
	input  wire logic        rvalid,
	output var  logic        rready
);
	assign wstrb = 4'hF;

	// ==========================================================
	// Channel handshakes: each valid holds until its own ready edge
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awvalid <= 1'b0;
			wvalid  <= 1'b0;
			bready  <= 1'b0;
			arvalid <= 1'b0;
			rready  <= 1'b0;
			done    <= 1'b0;
		end else begin
			if (go) begin
				done <= 1'b0;
				awvalid <= we;
				wvalid  <= we;
				bready  <= we;
				arvalid <= !we;
				rready  <= !we;
				awaddr  <= addr;
				araddr  <= addr;
				wdata   <= data;
			end
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			// Response is taken as soon as bvalid meets bready
			if (bready && bvalid) begin
				bready   <= 1'b0;
				done     <= 1'b1;
				rsp_code <= bresp;
			end
			if (arvalid && arready) arvalid <= 1'b0;
			if (rready && rvalid) begin
				rready   <= 1'b0;
				done     <= 1'b1;
				rsp_code <= rresp;
				rsp_data <= rdata;
			end
		end
	end
endmodule
`default_nettype wire

/* File: hw/pesr_core.sv */
// Purpose: Charge pump enable/lock/retention and high-voltage sense routing control
// Assumes: Operating mode and pin levels come from the chip; AXI4-Lite slave on aclk
// Notes:   Answers one write and one read at a time; reads on the accepting edge, writes one cycle after acceptance
//
// Summary of operation
// (R1) Pump off in init, switchable only in normal
// (R2) Lock bit set refuses pump enable changes
// (R3) Pump stays on through low-power and fail-safe modes
// (R4) Overvoltage never switches the pump off
// (R5) Pump enable bit reads back pump state
// (R6) Spread modulation rate field drives modulator select
// (R7) Measurement off and switch open after reset
// (R8) Measure enable closes switch only in normal
// (R9) Other modes open switch, setting stays stored
// (R10) Measurement disables pulls and gates pin signals
// (R11) Measurement ignores wake/io configs, writes still accepted
// (R12) Measurement stops wake flag and level updates
// (R13) Sleep with only gated wakes faults, goes restart
// (R14) Io config change during measurement sets fault
// (R15) Measure enable refused unless io pin off
// (R16) Measurement disables fail output, io and wake
// (R17) Fail-safe with measurement keeps config, switch open
// (R18) Fail-safe without measurement activates sense wake
// (R19) Wake enables stored but ignored during measurement
// (R20) Access fault stays set until software clears
//
// The placing of the registers and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module pesr_core (
	input  wire logic                 aclk,
	input  wire logic                 aresetn,
	input  wire logic                 clk_en,
	// AXI4-Lite slave
	input  wire logic [7:0]           s_axi_awaddr,
	input  wire logic                 s_axi_awvalid,
	output var  logic                 s_axi_awready,
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output var  logic                 s_axi_wready,
	output var  logic [1:0]           s_axi_bresp,
	output var  logic                 s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	input  wire logic [7:0]           s_axi_araddr,
	input  wire logic                 s_axi_arvalid,
	output var  logic                 s_axi_arready,
	output var  logic [31:0]          s_axi_rdata,
	output var  logic [1:0]           s_axi_rresp,
	output var  logic                 s_axi_rvalid,
	input  wire logic                 s_axi_rready,
	// Chip side
	input  wire pesr_pkg::pesr_mode_t chip_mode,
	input  wire logic                 sleep_request,
	input  wire logic                 supply_overvoltage,
	input  wire logic                 hv_sense_input,
	input  wire logic                 io_pin_level,
	input  wire logic                 hv_sense_wake_event,
	input  wire logic                 io_pin_wake_event,
	input  wire logic                 fail_output_request,
	output var  logic                 pump_gate_output,
	output var  logic [1:0]           spread_mod_rate,
	output var  logic                 measure_switch,
	output var  logic                 pull_enable,
	output var  logic [1:0]           pull_config_out,
	output var  logic [3:0]           wake_control_out,
	output var  logic [2:0]           io_function_out,
	output var  logic                 fail_output,
	output var  logic                 sense_wake_active,
	output var  logic                 io_pin_wake_active,
	output var  logic                 restart_request
);
	import pesr_pkg::*;

	// ==========================================================
	// State
	typedef struct packed {
		logic        awdone;
		logic [7:0]  awaddr;
		logic        wdone;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic        pump_en;
		logic        lock;
		logic [1:0]  ss_rate;
		logic        meas_en;
		logic        fo_test;
		logic [2:0]  io_cfg;
		logic        sense_wake_enable, iowk_en, other_wk;
		logic [1:0]  pull_cfg;
		logic [3:0]  wctrl;
		logic        acc_fault, wk_flag, io_flag, wk_lvl, io_lvl;
		logic        sense_s1, sense_s2, io_s1, io_s2;
		logic        wkev_s1, wkev_s2, ioev_s1, ioev_s2;
		logic        pump_out, switch_out, pull_out;
		logic [1:0]  pullc_out;
		logic [3:0]  wctrl_out;
		logic [2:0]  iofn_out;
		logic        fo_out, swk_out, iowk_out, restart_out;
		logic [1:0]  ss_out;
	} pesr_state_t;

	pesr_state_t st_reg;
	pesr_state_t st_next;

	logic        wr_fire;
	logic        rd_fire;
	logic        normal;
	logic        failsafe;
	logic [31:0] wd;
	logic        sleep_fault;
	logic        io_change;

	// Merge byte lanes into the current word for the addressed register
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// ==========================================================
	// Next-state logic
	always_comb begin
		st_next = st_reg;
		normal = (chip_mode == PESR_MODE_NORMAL);
		failsafe = (chip_mode == PESR_MODE_FAILSAFE);
		wr_fire = st_reg.awdone && st_reg.wdone && !st_reg.bvalid;
		rd_fire = s_axi_arvalid && !st_reg.rvalid;
		wd = 32'h0;
		io_change = 1'b0;
		// Only gated sources armed: sleep would never wake, so refuse it
		sleep_fault = sleep_request && st_reg.meas_en && !st_reg.other_wk
			&& (st_reg.sense_wake_enable || st_reg.iowk_en); // see (R13)

		// Address and data channels accepted independently, in any order
		if (s_axi_awvalid && !st_reg.awdone) begin
			st_next.awdone = 1'b1;
			st_next.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !st_reg.wdone) begin
			st_next.wdone = 1'b1;
			st_next.wdata = s_axi_wdata;
			st_next.wstrb = s_axi_wstrb;
		end
		// Pin synchronisers; first stage feeds only the second
		st_next.sense_s1 = hv_sense_input;
		st_next.sense_s2 = st_reg.sense_s1;
		st_next.io_s1 = io_pin_level;
		st_next.io_s2 = st_reg.io_s1;
		st_next.wkev_s1 = hv_sense_wake_event;
		st_next.wkev_s2 = st_reg.wkev_s1;
		st_next.ioev_s1 = io_pin_wake_event;
		st_next.ioev_s2 = st_reg.ioev_s1;
		// Wake status follows pins only while measurement is off
		if (!st_reg.meas_en) begin // see (R12)
			st_next.wk_lvl = st_reg.sense_s2;
			st_next.io_lvl = st_reg.io_s2;
		end

		// Register writes
		if (wr_fire) begin
			st_next.awdone = 1'b0;
			st_next.wdone = 1'b0;
			st_next.bvalid = 1'b1;
			st_next.bresp = PESR_RESP_OK;
			case (st_reg.awaddr)
				PESR_OFS_PUMP: begin
					wd = merge({26'h0, st_reg.ss_rate, 2'h0, st_reg.lock, st_reg.pump_en},
						st_reg.wdata, st_reg.wstrb);
					// Lock freezes the enable; lock itself may still be cleared
					if (!st_reg.lock && normal) begin // see (R1) (R2)
						st_next.pump_en = wd[PESR_B_PUMP_EN];
					end
					st_next.lock = wd[PESR_B_LOCK];
					st_next.ss_rate = wd[PESR_B_SS_LO +: PESR_SS_W]; // see (R6)
				end
				PESR_OFS_MEAS: begin
					wd = merge({27'h0, st_reg.fo_test, 3'h0, st_reg.meas_en},
						st_reg.wdata, st_reg.wstrb);
					// Setting measurement needs the io pin switched off first
					if (wd[PESR_B_MEAS_EN] && !st_reg.meas_en && st_reg.io_cfg != PESR_IO_OFF) begin
						st_next.acc_fault = 1'b1; // see (R15)
					end else begin
						st_next.meas_en = wd[PESR_B_MEAS_EN];
					end
					st_next.fo_test = wd[PESR_B_FO_TEST];
				end
				PESR_OFS_IOCFG: begin
					wd = merge({29'h0, st_reg.io_cfg}, st_reg.wdata, st_reg.wstrb);
					io_change = (wd[PESR_IOCFG_W-1:0] != st_reg.io_cfg);
					st_next.io_cfg = wd[PESR_IOCFG_W-1:0]; // see (R11)
					if (io_change && st_reg.meas_en) begin
						st_next.acc_fault = 1'b1; // see (R14)
					end
				end
				PESR_OFS_WAKE: begin
					wd = merge({20'h0, st_reg.wctrl, 2'h0, st_reg.pull_cfg, 1'b0,
						st_reg.other_wk, st_reg.iowk_en, st_reg.sense_wake_enable}, st_reg.wdata, st_reg.wstrb);
					st_next.sense_wake_enable = wd[PESR_B_SENSE_WAKE_ENABLE]; // see (R19)
					st_next.iowk_en = wd[PESR_B_IOWK_EN];
					st_next.other_wk = wd[PESR_B_OTHER_WK];
					st_next.pull_cfg = wd[PESR_B_PULL_LO +: PESR_PULL_W]; // see (R11)
					st_next.wctrl = wd[PESR_B_WCTRL_LO +: PESR_WCTRL_W];
				end
				PESR_OFS_FLAGS: begin
					// Write one to clear the sticky flags
					if (st_reg.wstrb[0]) begin
						if (st_reg.wdata[PESR_B_ACC_FAULT]) st_next.acc_fault = 1'b0; // see (R20)
						if (st_reg.wdata[PESR_B_WK_FLAG]) st_next.wk_flag = 1'b0;
						if (st_reg.wdata[PESR_B_IO_FLAG]) st_next.io_flag = 1'b0;
					end
				end
				PESR_OFS_STATUS: st_next.bresp = PESR_RESP_OK;
				default: st_next.bresp = PESR_RESP_ERR;
			endcase
		end
		if (st_reg.bvalid && s_axi_bready) begin
			st_next.bvalid = 1'b0;
		end
		// Hardware sets win over software clears
		if (!st_reg.meas_en && st_reg.wkev_s2) st_next.wk_flag = 1'b1; // see (R12)
		if (!st_reg.meas_en && st_reg.ioev_s2) st_next.io_flag = 1'b1;
		if (sleep_fault) st_next.acc_fault = 1'b1; // see (R13) (R20)
		// Pump off in init; other modes keep whatever was set (no overvoltage term)
		if (chip_mode == PESR_MODE_INIT) begin
			st_next.pump_en = 1'b0; // see (R1)
		end
		// Register reads
		if (rd_fire) begin
			st_next.rvalid = 1'b1;
			st_next.rresp = PESR_RESP_OK;
			case (s_axi_araddr)
				PESR_OFS_PUMP:   st_next.rdata = {26'h0, st_reg.ss_rate, 2'h0, st_reg.lock,
					st_reg.pump_en}; // see (R5)
				PESR_OFS_MEAS:   st_next.rdata = {27'h0, st_reg.fo_test, 3'h0, st_reg.meas_en};
				PESR_OFS_IOCFG:  st_next.rdata = {29'h0, st_reg.io_cfg};
				PESR_OFS_WAKE:   st_next.rdata = {20'h0, st_reg.wctrl, 2'h0, st_reg.pull_cfg,
					1'b0, st_reg.other_wk, st_reg.iowk_en, st_reg.sense_wake_enable};
				PESR_OFS_STATUS: st_next.rdata = {25'h0, st_reg.switch_out, st_reg.pump_out,
					st_reg.io_lvl, st_reg.wk_lvl, 3'h0};
				PESR_OFS_FLAGS:  st_next.rdata = {29'h0, st_reg.io_flag, st_reg.wk_flag,
					st_reg.acc_fault};
				default: begin
					st_next.rdata = 32'h0;
					st_next.rresp = PESR_RESP_ERR;
				end
			endcase
		end
		if (st_reg.rvalid && s_axi_rready) begin
			st_next.rvalid = 1'b0;
		end

		// Output stage, all registered
		st_next.pump_out = st_reg.pump_en; // see (R3) (R4)
		st_next.ss_out = st_reg.ss_rate;
		st_next.switch_out = st_reg.meas_en && normal; // see (R8) (R9) (R17)
		st_next.pull_out = !st_reg.meas_en; // see (R10)
		st_next.pullc_out = st_reg.meas_en ? 2'h0 : st_reg.pull_cfg; // see (R11)
		st_next.wctrl_out = st_reg.meas_en ? 4'h0 : st_reg.wctrl;
		st_next.iofn_out = st_reg.meas_en ? PESR_IO_OFF : st_reg.io_cfg; // see (R16)
		st_next.fo_out = !st_reg.meas_en && st_reg.io_cfg == PESR_IO_FAIL
			&& (st_reg.fo_test || fail_output_request); // see (R16)
		st_next.swk_out = !st_reg.meas_en && (st_reg.sense_wake_enable || failsafe); // see (R18) (R19)
		st_next.iowk_out = !st_reg.meas_en && st_reg.iowk_en && st_reg.io_cfg == PESR_IO_WAKE; // see (R19)
		st_next.restart_out = sleep_fault; // see (R13)
	end

	// ==========================================================
	// State register; clock enable freezes everything
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_reg <= '0; // see (R7)
		end else if (clk_en) begin
			st_reg <= st_next;
		end
	end

	// Port mapping
	assign s_axi_awready = !st_reg.awdone;
	assign s_axi_wready = !st_reg.wdone;
	assign s_axi_bvalid = st_reg.bvalid;
	assign s_axi_bresp = st_reg.bresp;
	assign s_axi_arready = !st_reg.rvalid;
	assign s_axi_rvalid = st_reg.rvalid;
	assign s_axi_rdata = st_reg.rdata;
	assign s_axi_rresp = st_reg.rresp;
	assign pump_gate_output = st_reg.pump_out;
	assign spread_mod_rate = st_reg.ss_out;
	assign measure_switch = st_reg.switch_out;
	assign pull_enable = st_reg.pull_out;
	assign pull_config_out = st_reg.pullc_out;
	assign wake_control_out = st_reg.wctrl_out;
	assign io_function_out = st_reg.iofn_out;
	assign fail_output = st_reg.fo_out;
	assign sense_wake_active = st_reg.swk_out;
	assign io_pin_wake_active = st_reg.iowk_out;
	assign restart_request = st_reg.restart_out;

	// ==========================================================
	// Assertions
	property p_init_off;
		@(posedge aclk) disable iff (!aresetn)
		(clk_en && chip_mode == PESR_MODE_INIT) ##1 clk_en |=> !pump_gate_output;
	endproperty
	a_init_off: assert property (p_init_off) else $error("pump on in init"); // see (R1)
	property p_lock_holds;
		@(posedge aclk) disable iff (!aresetn)
		(clk_en && st_reg.lock && chip_mode != PESR_MODE_INIT) |=> $stable(st_reg.pump_en);
	endproperty
	a_lock_holds: assert property (p_lock_holds) else $error("locked pump changed"); // see (R2)
	property p_ov_ignored;
		@(posedge aclk) disable iff (!aresetn)
		(clk_en && supply_overvoltage && st_reg.pump_en && chip_mode != PESR_MODE_INIT
			&& !wr_fire) |=> st_reg.pump_en;
	endproperty
	a_ov_ignored: assert property (p_ov_ignored) else $error("pump dropped"); // see (R4)
	// Switch lags one cycle; a frozen cycle keeps the older value, so skip it
	property p_switch_normal;
		@(posedge aclk) disable iff (!aresetn)
		($past(clk_en) && measure_switch) |-> $past(normal) && $past(st_reg.meas_en);
	endproperty
	a_switch_normal: assert property (p_switch_normal) else $error("switch closed badly"); // see (R8)
	property p_meas_refused;
		@(posedge aclk) disable iff (!aresetn)
		(clk_en && wr_fire && st_reg.awaddr == PESR_OFS_MEAS && st_reg.wstrb[0] && st_reg.wdata[PESR_B_MEAS_EN]
			&& !st_reg.meas_en && st_reg.io_cfg != PESR_IO_OFF) |=> !st_reg.meas_en && st_reg.acc_fault;
	endproperty
	a_meas_refused: assert property (p_meas_refused) else $error("meas enable not refused"); // see (R15)
	sequence s_sleep_bad;
		clk_en && sleep_fault;
	endsequence
	property p_sleep_restart;
		@(posedge aclk) disable iff (!aresetn)
		s_sleep_bad |=> restart_request && st_reg.acc_fault;
	endproperty
	a_sleep_restart: assert property (p_sleep_restart) else $error("sleep not refused"); // see (R13)
	property p_flags_frozen;
		@(posedge aclk) disable iff (!aresetn)
		(clk_en && st_reg.meas_en && !st_reg.wk_flag) |=> !st_reg.wk_flag;
	endproperty
	a_flags_frozen: assert property (p_flags_frozen) else $error("wake flag set in meas"); // see (R12)
	property p_fault_sticky;
		@(posedge aclk) disable iff (!aresetn)
		(clk_en && st_reg.acc_fault && !(wr_fire && st_reg.awaddr == PESR_OFS_FLAGS))
			|=> st_reg.acc_fault;
	endproperty
	a_fault_sticky: assert property (p_fault_sticky) else $error("fault flag lost"); // see (R20)
	property p_fo_gated;
		@(posedge aclk) disable iff (!aresetn)
		(clk_en && st_reg.meas_en) |=> !fail_output && !pull_enable;
	endproperty
	a_fo_gated: assert property (p_fo_gated) else $error("fail out active in meas"); // see (R16)

endmodule

`default_nettype wire
